// File: llj_pkg.sv
/*
 * llj_pkg: shared constants of the line loss / jitter smoother / loopback block.
 * Assumes a 10 MHz system clock and one line channel per instance.
 */
package llj_pkg;

	// system clock
	localparam int SYS_CLK_HZ = 10_000_000;

	// loss of signal run lengths, in bit periods, and loss level in dB
	localparam int LOS_SHORT_BITS = 192;
	localparam int LOS_LONG_BITS  = 2048;
	localparam int LOS_CLEAR_BITS = 192;
	localparam int LOS_LEVEL_DB   = 3;

	// synchronised pin positions
	localparam int PIN_RX_CLK  = 0;
	localparam int PIN_RX_POS  = 1;
	localparam int PIN_RX_NEG  = 2;
	localparam int PIN_TX_CLK  = 3;
	localparam int PIN_TX_POS  = 4;
	localparam int PIN_TX_NEG  = 5;
	localparam int PIN_REF_CLK = 6;
	localparam int PIN_LVL_LOW = 7;
	localparam int PIN_LVL_OK  = 8;
	localparam int PIN_COUNT   = 9;

	// smoother storage: 16 words of 8 bit pairs
	localparam int FIFO_DEPTH     = 16;
	localparam int PAIR_W         = 2;
	localparam int PAIRS_PER_WORD = 8;
	localparam int FIFO_WORD_W    = PAIR_W * PAIRS_PER_WORD;
	localparam int CNT_W          = $clog2(FIFO_DEPTH + 1);

	localparam int DEPTH_BITS_DEEP    = 128;
	localparam int DEPTH_BITS_SHALLOW = 32;
	localparam logic [CNT_W-1:0] LIMIT_WORDS_DEEP    = CNT_W'(DEPTH_BITS_DEEP / PAIRS_PER_WORD);
	localparam logic [CNT_W-1:0] LIMIT_WORDS_SHALLOW = CNT_W'(DEPTH_BITS_SHALLOW / PAIRS_PER_WORD);

	// limit trip thresholds, peak-to-peak unit intervals
	localparam int JIT_LIMIT_UI_DEEP    = 120;
	localparam int JIT_LIMIT_UI_SHALLOW = 28;

	localparam int FILL_W = 9;
	localparam logic [FILL_W-1:0] CENTER_DEEP    = FILL_W'(DEPTH_BITS_DEEP / 2);
	localparam logic [FILL_W-1:0] CENTER_SHALLOW = FILL_W'(DEPTH_BITS_SHALLOW / 2);
	localparam logic [FILL_W-1:0] FILL_HI_DEEP   = FILL_W'(DEPTH_BITS_DEEP / 2 + JIT_LIMIT_UI_DEEP / 2);
	localparam logic [FILL_W-1:0] FILL_LO_DEEP   = FILL_W'(DEPTH_BITS_DEEP / 2 - JIT_LIMIT_UI_DEEP / 2);
	localparam logic [FILL_W-1:0] FILL_HI_SHALLOW =
		FILL_W'(DEPTH_BITS_SHALLOW / 2 + JIT_LIMIT_UI_SHALLOW / 2);
	localparam logic [FILL_W-1:0] FILL_LO_SHALLOW =
		FILL_W'(DEPTH_BITS_SHALLOW / 2 - JIT_LIMIT_UI_SHALLOW / 2);

	// path select {hi, lo}
	localparam logic [1:0] PATH_RX = 2'h1;
	localparam logic [1:0] PATH_TX = 2'h2;

	// smoothing oscillator: nominal rate and loop gain from corner frequency
	localparam int NCO_W         = 32;
	localparam int E1_RATE_HZ    = 2_048_000;
	localparam int T1_RATE_HZ    = 1_544_000;
	localparam int CORNER_T1_MHZ = 3750;
	localparam int CORNER_E1_MHZ = 600;
	localparam int TWO_PI_MILLI  = 6283;
	localparam logic [NCO_W-1:0] NCO_INC_E1 =
		NCO_W'((64'(E1_RATE_HZ) << 32) / 64'(SYS_CLK_HZ));
	localparam logic [NCO_W-1:0] NCO_INC_T1 =
		NCO_W'((64'(T1_RATE_HZ) << 32) / 64'(SYS_CLK_HZ));
	localparam logic signed [NCO_W-1:0] NCO_GAIN_E1 = NCO_W'((64'(CORNER_E1_MHZ)
		* 64'(TWO_PI_MILLI) * (64'h1 << 32)) / (64'd1_000_000 * 64'(SYS_CLK_HZ)));
	localparam logic signed [NCO_W-1:0] NCO_GAIN_T1 = NCO_W'((64'(CORNER_T1_MHZ)
		* 64'(TWO_PI_MILLI) * (64'h1 << 32)) / (64'd1_000_000 * 64'(SYS_CLK_HZ)));

	typedef logic [PAIR_W-1:0] llj_pair_t;

endpackage

// File: llj_stream_if.sv
/*
 * llj_stream_if: valid/ready word channel between the block's own modules.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface llj_stream_if #(parameter int WIDTH = 16);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// File: llj_fifo.sv
/*
 * llj_fifo: synchronous word FIFO with valid/ready on both sides.
 * Assumes a single clock; a word moves when valid and ready are both high.
 */
`timescale 1ns/1ps
module llj_fifo #(
	parameter int WIDTH = llj_pkg::FIFO_WORD_W,
	parameter int DEPTH = llj_pkg::FIFO_DEPTH
) (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_reset_n,
	llj_stream_if.snk                       wr,
	llj_stream_if.src                       rd,
	output logic [$clog2(DEPTH+1)-1:0]      o_count
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;

	wire push = wr.valid && wr.ready;
	wire pop  = rd.valid && rd.ready;

	assign wr.ready = (count_reg != CW'(DEPTH));
	assign rd.valid = (count_reg != '0);
	assign rd.data  = mem[rd_ptr_reg];
	assign o_count  = count_reg;

	always_ff @(posedge i_sys_clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= wr.data;
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			wr_ptr_reg <= push ? PW'(wr_ptr_reg + 1'h1) : wr_ptr_reg;
			rd_ptr_reg <= pop ? PW'(rd_ptr_reg + 1'h1) : rd_ptr_reg;
			count_reg  <= CW'(count_reg + CW'(push) - CW'(pop));
		end
	end

	AST_FIFO_NO_OVERRUN: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		count_reg == CW'(DEPTH) |-> !wr.ready)
		else $error("fifo accepts a write while full");
endmodule

// File: llj_run_counter.sv
/*
 * llj_run_counter: counts consecutive bit ticks while a condition holds.
 * Assumes i_tick is a one-cycle strobe per bit period on the system clock.
 */
`timescale 1ns/1ps
module llj_run_counter #(
	parameter int LIMIT = 192
) (
	input  wire logic i_sys_clk,
	input  wire logic i_reset_n,
	input  wire logic i_tick,
	input  wire logic i_cond,
	output logic      o_done
);
	localparam int CW = $clog2(LIMIT + 1);

	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic          done_reg;

	// a broken run starts again from zero
	assign count_next = !i_tick ? count_reg :
		!i_cond ? '0 :
		(count_reg == CW'(LIMIT)) ? count_reg : CW'(count_reg + 1'h1);
	assign o_done = done_reg;

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			count_reg <= '0;
			done_reg  <= 1'h0;
		end
		else
		begin
			count_reg <= count_next;
			done_reg  <= (count_next == CW'(LIMIT));
		end
	end

	AST_RUN_RESTART: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_tick && !i_cond |=> count_reg == '0 && !o_done)
		else $error("run count not restarted on broken condition");
	AST_RUN_DONE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		$rose(o_done) |-> $past(i_tick) && $past(count_reg) == CW'(LIMIT - 1))
		else $error("run done without the full run length");
endmodule

// File: llj_line_top.sv
/*
 * llj_line_top: line-side digital control of one T1/E1 channel: loss of signal
 * detection, jitter smoother with bit FIFO and oscillator, and loopback muxing.
 * Assumes line pins, framer clocks and reference clock are asynchronous and
 * sliced to logic levels; config bits are static and on the system clock.
 */
`timescale 1ns/1ps
module llj_line_top (
	input  wire logic i_sys_clk,
	input  wire logic i_reset_n,
	input  wire logic i_line_rx_plus,
	input  wire logic i_line_rx_minus,
	input  wire logic i_rx_recovered_clk,
	input  wire logic i_level_below_loss,
	input  wire logic i_level_at_sens,
	input  wire logic i_transmit_clock_in,
	input  wire logic i_tx_positive_data,
	input  wire logic i_tx_negative_data,
	input  wire logic i_smoother_reference_clock,
	input  wire logic i_e1_long_criterion,
	input  wire logic i_t1_mode,
	input  wire logic i_fifo_depth_select,
	input  wire logic i_smoother_path_select_hi,
	input  wire logic i_smoother_path_select_lo,
	input  wire logic i_far_loop_enable,
	input  wire logic i_near_loop_enable,
	input  wire logic i_analog_loop_enable,
	input  wire logic i_limit_trip_clear,
	output logic      o_line_tx_plus,
	output logic      o_line_tx_minus,
	output logic      o_rx_positive_data,
	output logic      o_rx_negative_data,
	output logic      o_rx_clk,
	output logic      o_loss_of_signal,
	output logic      o_rx_carrier_loss,
	output logic      o_smoother_limit_trip,
	output logic      o_smoothed_clk
);
	import llj_pkg::*;

	// pin synchronisers: a change counts once stages two and three agree
	logic [PIN_COUNT-1:0] pins_raw;
	logic [PIN_COUNT-1:0] s1_reg;
	logic [PIN_COUNT-1:0] s2_reg;
	logic [PIN_COUNT-1:0] s3_reg;
	logic [PIN_COUNT-1:0] filt_reg;
	logic [PIN_COUNT-1:0] filt_prev_reg;

	assign pins_raw = {i_level_at_sens, i_level_below_loss, i_smoother_reference_clock,
		i_tx_negative_data, i_tx_positive_data, i_transmit_clock_in,
		i_line_rx_minus, i_line_rx_plus, i_rx_recovered_clk};

	wire [PIN_COUNT-1:0] agree     = ~(s2_reg ^ s3_reg);
	wire [PIN_COUNT-1:0] filt_next = (agree & s3_reg) | (~agree & filt_reg);
	wire [PIN_COUNT-1:0] rise      = filt_reg & ~filt_prev_reg;

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			s1_reg        <= '0;
			s2_reg        <= '0;
			s3_reg        <= '0;
			filt_reg      <= '0;
			filt_prev_reg <= '0;
		end
		else
		begin
			s1_reg        <= pins_raw;
			s2_reg        <= s1_reg;
			s3_reg        <= s2_reg;
			filt_reg      <= filt_next;
			filt_prev_reg <= filt_reg;
		end
	end

	wire       rx_line_tick = rise[PIN_RX_CLK];
	wire       tx_tick      = rise[PIN_TX_CLK];
	wire       ref_tick     = rise[PIN_REF_CLK];
	llj_pair_t rx_line_data;
	llj_pair_t tx_pin_data;
	assign rx_line_data = {filt_reg[PIN_RX_POS], filt_reg[PIN_RX_NEG]};
	assign tx_pin_data  = {filt_reg[PIN_TX_POS], filt_reg[PIN_TX_NEG]};

	// loss of signal, timed by reference clock bit periods
	logic los_reg;
	logic decl_short_done;
	logic decl_long_done;
	logic clear_done;

	llj_run_counter #(.LIMIT(LOS_SHORT_BITS)) u_decl_short (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_tick    (ref_tick),
		.i_cond    (filt_reg[PIN_LVL_LOW]),
		.o_done    (decl_short_done)
	);
	llj_run_counter #(.LIMIT(LOS_LONG_BITS)) u_decl_long (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_tick    (ref_tick),
		.i_cond    (filt_reg[PIN_LVL_LOW]),
		.o_done    (decl_long_done)
	);
	llj_run_counter #(.LIMIT(LOS_CLEAR_BITS)) u_clear (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_tick    (ref_tick),
		.i_cond    (filt_reg[PIN_LVL_OK]),
		.o_done    (clear_done)
	);

	wire decl_done = i_e1_long_criterion ? decl_long_done : decl_short_done;
	wire los_next  = los_reg ? !clear_done : decl_done;

	// path and loopback selection
	wire [1:0] path    = {i_smoother_path_select_hi, i_smoother_path_select_lo};
	wire       path_rx = (path == PATH_RX);
	wire       path_tx = (path == PATH_TX);
	wire       att_on  = path_rx || path_tx;

	logic      nco_tick_reg;
	llj_pair_t att_pair_reg;
	logic      line_tx_plus_reg;
	logic      line_tx_minus_reg;

	// far loop sources the transmit side from the line receiver
	wire       tx_src_tick = i_far_loop_enable ? rx_line_tick : tx_tick;
	llj_pair_t tx_src_data;
	assign tx_src_data = i_far_loop_enable ? rx_line_data : tx_pin_data;

	wire       tx_line_tick = path_tx ? nco_tick_reg : tx_src_tick;
	llj_pair_t tx_line_data;
	assign tx_line_data = path_tx ? att_pair_reg : tx_src_data;

	// receiver input: analog loop takes line output, near loop framer data
	wire rx_src_tick = i_analog_loop_enable ? tx_line_tick :
		i_near_loop_enable ? tx_tick : rx_line_tick;
	llj_pair_t rx_src_data;
	assign rx_src_data = i_analog_loop_enable ? {line_tx_plus_reg, line_tx_minus_reg} :
		i_near_loop_enable ? tx_pin_data : rx_line_data;

	wire       att_in_tick = path_rx ? rx_src_tick : (path_tx && tx_src_tick);
	llj_pair_t att_in_data;
	assign att_in_data = path_rx ? rx_src_data : tx_src_data;

	wire       rx_out_tick = path_rx ? nco_tick_reg : rx_src_tick;
	llj_pair_t rx_out_data;
	assign rx_out_data = path_rx ? att_pair_reg : rx_src_data;
	wire       rx_clk_tick = los_reg ? ref_tick : rx_out_tick;

	// smoother writer: packs bit pairs into words
	llj_stream_if #(.WIDTH(FIFO_WORD_W)) wr_if ();
	llj_stream_if #(.WIDTH(FIFO_WORD_W)) rd_if ();
	logic [CNT_W-1:0]       fifo_count;
	logic [FIFO_WORD_W-1:0] pack_reg;
	logic [2:0]             wr_idx_reg;
	logic [FIFO_WORD_W-1:0] unpack_reg;
	logic [3:0]             rd_left_reg;
	logic                   primed_reg;

	llj_fifo #(.WIDTH(FIFO_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.wr        (wr_if),
		.rd        (rd_if),
		.o_count   (fifo_count)
	);

	wire [CNT_W-1:0] limit_words = i_fifo_depth_select ? LIMIT_WORDS_DEEP :
		LIMIT_WORDS_SHALLOW;
	wire [FILL_W-1:0] center  = i_fifo_depth_select ? CENTER_DEEP : CENTER_SHALLOW;
	wire [FILL_W-1:0] fill_hi = i_fifo_depth_select ? FILL_HI_DEEP : FILL_HI_SHALLOW;
	wire [FILL_W-1:0] fill_lo = i_fifo_depth_select ? FILL_LO_DEEP : FILL_LO_SHALLOW;

	wire [FIFO_WORD_W-1:0] pack_next = {pack_reg[FIFO_WORD_W-PAIR_W-1:0], att_in_data};
	wire push_req  = att_in_tick && (wr_idx_reg == 3'h7);
	wire below_lim = fifo_count < limit_words;
	assign wr_if.valid = push_req && below_lim;
	assign wr_if.data  = pack_next;
	wire overflow  = push_req && !(wr_if.ready && below_lim);

	// smoother reader: the oscillator tick pulls bit pairs out
	wire need_word = nco_tick_reg && (rd_left_reg == 4'h0);
	assign rd_if.ready = need_word && primed_reg;
	wire underflow = need_word && primed_reg && !rd_if.valid;

	wire [FILL_W-1:0] fill = FILL_W'({fifo_count, 3'h0}) + FILL_W'(wr_idx_reg)
		+ FILL_W'(rd_left_reg);
	wire trip_event = primed_reg && (fill > fill_hi || fill < fill_lo
		|| overflow || underflow);

	// first order loop: rate follows fill error, gain sets the corner
	wire signed [FILL_W:0]    fill_err = $signed({1'h0, fill}) - $signed({1'h0, center});
	wire signed [NCO_W-1:0]   gain     = i_t1_mode ? NCO_GAIN_T1 : NCO_GAIN_E1;
	wire signed [NCO_W-1:0]   adj      = primed_reg ? NCO_W'(gain * fill_err) : '0;
	wire        [NCO_W-1:0]   nominal  = i_t1_mode ? NCO_INC_T1 : NCO_INC_E1;
	logic       [NCO_W-1:0]   nco_acc_reg;
	wire        [NCO_W:0]     nco_sum  = {1'h0, nco_acc_reg} + {1'h0, NCO_W'(nominal + adj)};

	logic limit_trip_reg;
	logic rx_clk_d_reg;
	logic rx_clk_reg;
	logic rx_pos_reg;
	logic rx_neg_reg;

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pack_reg    <= '0;
			wr_idx_reg  <= '0;
			unpack_reg  <= '0;
			rd_left_reg <= '0;
			primed_reg  <= 1'h0;
		end
		else
		begin
			// bursty input is absorbed here; output rate is the oscillator's
			if (att_in_tick)
			begin
				pack_reg   <= pack_next;
				wr_idx_reg <= wr_idx_reg + 3'h1;
			end
			if (rd_if.ready && rd_if.valid)
			begin
				unpack_reg  <= {rd_if.data[FIFO_WORD_W-PAIR_W-1:0], 2'h0};
				rd_left_reg <= 4'(PAIRS_PER_WORD - 1);
			end
			else if (nco_tick_reg && rd_left_reg != 4'h0)
			begin
				unpack_reg  <= {unpack_reg[FIFO_WORD_W-PAIR_W-1:0], 2'h0};
				rd_left_reg <= rd_left_reg - 4'h1;
			end
			primed_reg <= att_on && !underflow && (primed_reg || fill >= center);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			nco_acc_reg  <= '0;
			nco_tick_reg <= 1'h0;
			att_pair_reg <= '0;
		end
		else
		begin
			nco_acc_reg  <= nco_sum[NCO_W-1:0];
			nco_tick_reg <= nco_sum[NCO_W];
			if (nco_tick_reg)
				att_pair_reg <= !rd_if.ready ? unpack_reg[FIFO_WORD_W-1 -: PAIR_W] :
					rd_if.valid ? rd_if.data[FIFO_WORD_W-1 -: PAIR_W] : 2'h0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			los_reg           <= 1'h0;
			limit_trip_reg    <= 1'h0;
			line_tx_plus_reg  <= 1'h0;
			line_tx_minus_reg <= 1'h0;
			rx_pos_reg        <= 1'h0;
			rx_neg_reg        <= 1'h0;
			rx_clk_d_reg      <= 1'h0;
			rx_clk_reg        <= 1'h0;
		end
		else
		begin
			los_reg        <= los_next;
			limit_trip_reg <= trip_event || (limit_trip_reg && !i_limit_trip_clear);
			if (tx_line_tick)
			begin
				line_tx_plus_reg  <= tx_line_data[1];
				line_tx_minus_reg <= tx_line_data[0];
			end
			if (rx_out_tick)
			begin
				rx_pos_reg <= rx_out_data[1];
				rx_neg_reg <= rx_out_data[0];
			end
			rx_clk_d_reg <= rx_clk_tick;
			rx_clk_reg   <= rx_clk_tick || rx_clk_d_reg;
		end
	end

	assign o_line_tx_plus        = line_tx_plus_reg;
	assign o_line_tx_minus       = line_tx_minus_reg;
	assign o_rx_positive_data    = rx_pos_reg;
	assign o_rx_negative_data    = rx_neg_reg;
	assign o_rx_clk              = rx_clk_reg;
	assign o_loss_of_signal      = los_reg;
	assign o_rx_carrier_loss     = los_reg;
	assign o_smoother_limit_trip = limit_trip_reg;
	assign o_smoothed_clk        = nco_acc_reg[NCO_W-1];

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	AST_LOS_DECLARE: assert property ($rose(los_reg) |->
		$past(i_e1_long_criterion ? decl_long_done : decl_short_done))
		else $error("loss declared without the run length of the mode");
	AST_LOS_CLEAR: assert property ($fell(los_reg) |-> $past(clear_done))
		else $error("loss cleared without a good level run");
	AST_DEPTH_LIMIT: assert property (wr_if.valid |-> fifo_count < limit_words)
		else $error("smoother filled beyond the selected depth");
	AST_BYPASS_NO_WRITE: assert property (!att_on |-> !wr_if.valid)
		else $error("smoother written while bypassed");
	AST_READ_ON_OSC: assert property (rd_if.ready |-> nco_tick_reg && primed_reg)
		else $error("smoother read without an oscillator tick");
	AST_TRIP_SET: assert property (trip_event |=> o_smoother_limit_trip)
		else $error("limit trip not set on excess jitter");
	AST_TRIP_HOLD: assert property (o_smoother_limit_trip && !i_limit_trip_clear
		|=> o_smoother_limit_trip)
		else $error("limit trip dropped without a clear");
	AST_FAR_LOOP: assert property (i_far_loop_enable && !path_tx && rx_line_tick
		|=> o_line_tx_plus == $past(filt_reg[PIN_RX_POS]))
		else $error("far loop does not return receive data");
	AST_NEAR_LOOP: assert property (i_near_loop_enable && !i_analog_loop_enable
		&& !path_rx && tx_tick |=> o_rx_positive_data == $past(filt_reg[PIN_TX_POS]))
		else $error("near loop does not carry transmit data");
	AST_ANALOG_LOOP: assert property (i_analog_loop_enable && !path_rx && tx_line_tick
		|=> o_rx_positive_data == $past(o_line_tx_plus))
		else $error("analog loop does not feed line output back");
	AST_CARRIER_CLK: assert property (los_reg && ref_tick |=> o_rx_clk)
		else $error("receive clock not taken from reference in carrier loss");
endmodule

// File: llj_partner.sv
/*
 * llj_partner: far-side bit clocks: reference, recovered receive, framer transmit.
 * Assumes the system clock; a stopped clock rests low.
 */
`timescale 1ns/1ps
module llj_partner (
	input  wire logic       i_sys_clk,
	input  wire logic [2:0] i_run,
	input  wire logic [3:0] i_tx_half,
	output logic            o_ref_clk,
	output logic            o_rx_clk,
	output logic            o_tx_clk
);
	logic [3:0] ref_cnt;
	logic [3:0] rx_cnt;
	logic [3:0] tx_cnt;
	// 1 MHz reference and receive clocks from a steady master
	// transmit clock may stop at any time, giving a gapped feed
	always_ff @(posedge i_sys_clk)
	begin
		ref_cnt <= (ref_cnt == 4'h4 || !i_run[0]) ? 4'h0 : ref_cnt + 4'h1;
		o_ref_clk <= i_run[0] & (o_ref_clk ^ (ref_cnt == 4'h4));
		rx_cnt <= (rx_cnt == 4'h4 || !i_run[1]) ? 4'h0 : rx_cnt + 4'h1;
		o_rx_clk <= i_run[1] & (o_rx_clk ^ (rx_cnt == 4'h4));
		tx_cnt <= (tx_cnt == i_tx_half - 4'h1 || !i_run[2]) ? 4'h0 : tx_cnt + 4'h1;
		o_tx_clk <= i_run[2] & (o_tx_clk ^ (tx_cnt == i_tx_half - 4'h1));
	end
endmodule

// File: testbench.sv
/*
 * testbench: loss of signal timing, smoother depth and limit trip, loopbacks.
 * Assumes llj_partner supplies the bit clocks; levels are driven here.
 */
`timescale 1ns/1ps
module testbench;
	import llj_pkg::*;
	logic       i_sys_clk = 1'b0;
	logic       i_reset_n = 1'b0;
	logic       below     = 1'b0;
	logic       at_sens   = 1'b1;
	logic       long_c    = 1'b0;
	logic       t1        = 1'b0;
	logic       depth     = 1'b0;
	logic [1:0] path      = 2'h0;
	logic [2:0] loops     = 3'h0;
	logic       clr       = 1'b0;
	logic       rxp       = 1'b0;
	logic       txp       = 1'b0;
	logic [2:0] run       = 3'h0;
	logic [3:0] tx_half   = 4'h2;
	logic       ref_clk, rx_clk_in, tx_clk;
	logic       lt_p, lt_m, rd_p, rd_m, rclk, los, rcl, trip, sclk;
	int         err_total = 0;
	int         compares  = 0;
	int         cycles    = 0;
	always #50 i_sys_clk = ~i_sys_clk;
	llj_partner u_llj_partner (.i_sys_clk(i_sys_clk), .i_run(run), .i_tx_half(tx_half),
		.o_ref_clk(ref_clk), .o_rx_clk(rx_clk_in), .o_tx_clk(tx_clk));
	llj_line_top u_llj_line_top (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
		.i_line_rx_plus(rxp), .i_line_rx_minus(~rxp), .i_rx_recovered_clk(rx_clk_in),
		.i_level_below_loss(below), .i_level_at_sens(at_sens),
		.i_transmit_clock_in(tx_clk), .i_tx_positive_data(txp), .i_tx_negative_data(~txp),
		.i_smoother_reference_clock(ref_clk), .i_e1_long_criterion(long_c), .i_t1_mode(t1),
		.i_fifo_depth_select(depth), .i_smoother_path_select_hi(path[1]),
		.i_smoother_path_select_lo(path[0]), .i_far_loop_enable(loops[2]),
		.i_near_loop_enable(loops[1]), .i_analog_loop_enable(loops[0]),
		.i_limit_trip_clear(clr), .o_line_tx_plus(lt_p), .o_line_tx_minus(lt_m),
		.o_rx_positive_data(rd_p), .o_rx_negative_data(rd_m), .o_rx_clk(rclk),
		.o_loss_of_signal(los), .o_rx_carrier_loss(rcl), .o_smoother_limit_trip(trip),
		.o_smoothed_clk(sclk));
	task automatic close_out;
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
	endtask
	task automatic refs(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp, input logic [3:0] m);
		compares++;
		if ((got & m) !== (exp & m))
		begin
			err_total++;
			$display("MISMATCH %0t got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic rst;
		@(posedge i_sys_clk);
		i_reset_n <= 1'b0;
		cyc(7);
		@(posedge i_sys_clk);
		i_reset_n <= 1'b1;
	endtask
	// set the level at a reference edge, then check just before and after n bits
	task automatic los_run(input int n, input logic b, input logic s);
		refs(1);
		below <= b;
		at_sens <= s;
		refs(n - 2);
		cyc(9);
		chk({2'b00, los, rcl}, {2'b00, s, s}, 4'h3);
		refs(1);
		cyc(9);
		chk({2'b00, los, rcl}, {2'b00, b, b}, 4'h3);
	endtask
	task automatic trip_run(input logic d, input logic t, input logic e, input int lo,
		input int hi);
		int   k;
		logic prev;
		rst;
		@(posedge i_sys_clk);
		depth <= d;
		t1 <= t;
		path <= PATH_TX;
		run <= 3'h5;
		cyc(150);
		@(posedge i_sys_clk);
		clr <= 1'b1;
		@(posedge i_sys_clk);
		clr <= 1'b0;
		cyc(800);
		chk({3'b000, trip}, {3'b000, e}, 4'h1);
		k = 0;
		prev = sclk;
		repeat (1000)
		begin
			@(negedge i_sys_clk);
			if (sclk === 1'b1 && prev === 1'b0)
				k++;
			prev = sclk;
		end
		chk({3'b000, k >= lo && k <= hi}, 4'h1, 4'h1);
	endtask
	task automatic loop_case(input logic [2:0] l, input logic rp, input logic tp,
		input logic [3:0] e, input logic [3:0] m);
		@(posedge i_sys_clk);
		loops <= l;
		rxp <= rp;
		txp <= tp;
		cyc(200);
		chk({lt_p, lt_m, rd_p, rd_m}, e, m);
	endtask
	// count receive clock pulses over 200 cycles, ref period is 10 cycles
	task automatic rclk_run(input int lo, input int hi);
		int   k;
		logic prev;
		k = 0;
		prev = rclk;
		repeat (200)
		begin
			@(negedge i_sys_clk);
			if (rclk === 1'b1 && prev === 1'b0)
				k++;
			prev = rclk;
		end
		chk({3'b000, k >= lo && k <= hi}, 4'h1, 4'h1);
	endtask
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (cycles == 45000)
		begin
			err_total++;
			close_out;
		end
	end
	initial
	begin
		cyc(7);
		chk({lt_p, lt_m, rd_p, rd_m}, 4'h0, 4'hf);
		chk({los, rcl, trip, rclk}, 4'h0, 4'hf);
		@(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		run <= 3'h1;
		refs(3);
		below <= 1'b1;
		at_sens <= 1'b0;
		refs(100);
		below <= 1'b0;
		los_run(192, 1'b1, 1'b0);
		los_run(192, 1'b0, 1'b1);
		@(posedge i_sys_clk);
		long_c <= 1'b1;
		los_run(2048, 1'b1, 1'b0);
		rclk_run(19, 21);
		los_run(192, 1'b0, 1'b1);
		rclk_run(0, 0);
		trip_run(1'b0, 1'b1, 1'b1, 140, 170);
		trip_run(1'b1, 1'b0, 1'b0, 190, 220);
		cyc(1000);
		chk({3'b000, trip}, 4'h1, 4'h1);
		@(posedge i_sys_clk);
		path <= 2'h0;
		run <= 3'h1;
		cyc(200);
		chk({3'b000, trip}, 4'h1, 4'h1);
		@(posedge i_sys_clk);
		clr <= 1'b1;
		@(posedge i_sys_clk);
		clr <= 1'b0;
		cyc(3);
		chk({3'b000, trip}, 4'h0, 4'h1);
		rst;
		@(posedge i_sys_clk);
		run <= 3'h7;
		tx_half <= 4'h5;
		loop_case(3'b000, 1'b1, 1'b0, 4'b0110, 4'hf);
		loop_case(3'b100, 1'b1, 1'b0, 4'b1000, 4'hc);
		loop_case(3'b100, 1'b0, 1'b1, 4'b0100, 4'hc);
		loop_case(3'b010, 1'b0, 1'b1, 4'b1010, 4'hf);
		loop_case(3'b110, 1'b0, 1'b1, 4'b0110, 4'hf);
		loop_case(3'b001, 1'b1, 1'b0, 4'b0101, 4'hf);
		close_out;
	end
endmodule
